/* File: boot_section_flash_protection_tb.sv */
// self-checking bench for the lock guard, with a flash stand-in on the far side
// assumes the guard answers stores and loads one cycle after the strobe
`timescale 1ns/100ps
module boot_section_flash_protection_tb;
  localparam logic [13:0] BootPc = 14'h3c00;
  localparam logic [13:0] AppPc  = 14'h0040;
  logic clk_sys = 0, rst_n = 0, vectorsInBoot = 0, storeStrobe = 0, lpmStrobe = 0, slowMode = 0;
  logic bootResetSelectFuse = 1, extLockProgram = 0, chipErase = 0, flashDone;
  logic flashEraseReq, flashWriteReq, bufWrite, lpmValid, storeRefused, cpuHalt, irqSuppress;
  logic [13:0] pcWordAddr = 0, resetVector;
  logic [7:0]  flashPointerHigh = 0, flashPointerLow = 0, flashReadData, flashPageAddr, lpmData;
  logic [15:0] storeData = 0, bufData, flashReadAddr;
  logic [5:0]  bufWordAddr;
  logic [3:0]  nvLockBits = 4'hf, extLockData = 4'hf, lockBits;
  bsfp_pkg::bsfp_op_t storeOp = bsfp_pkg::OP_FILL;
  int errors = 0, compares = 0, cycles = 0, expLock, k;
  logic [15:0] z;
  int wordQ[$];

  bsfp_guard bsfp_guard_inst (.clk_sys, .rst_n, .pcWordAddr, .vectorsInBoot, .storeStrobe,
    .storeOp, .flashPointerHigh, .flashPointerLow, .storeData, .lpmStrobe, .flashReadData,
    .bootResetSelectFuse, .nvLockBits, .extLockProgram, .extLockData, .chipErase, .flashDone,
    .flashEraseReq, .flashWriteReq, .flashPageAddr, .bufWrite, .bufWordAddr, .bufData,
    .flashReadAddr, .lpmData, .lpmValid, .storeRefused, .cpuHalt, .irqSuppress, .resetVector,
    .lockBits);
  bsfp_flash_model bsfp_flash_model_inst (.clk_sys, .rst_n, .flashEraseReq, .flashWriteReq,
    .flashReadAddr, .slowMode, .flashDone, .flashReadData);

  // clock and hang guard
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one store instruction; answers are sampled in the cycle after the strobe
  task automatic store(input logic [13:0] pc, input bsfp_pkg::bsfp_op_t op, input logic [15:0] zp,
                       input logic [15:0] d);
    @(posedge clk_sys);
    pcWordAddr <= pc;
    storeOp <= op;
    {flashPointerHigh, flashPointerLow} <= zp;
    storeData <= d;
    storeStrobe <= 1'b1;
    @(posedge clk_sys);
    storeStrobe <= 1'b0;
    #1;
  endtask : store

  task automatic lpm(input logic [13:0] pc, input logic [15:0] zp, input bit blk);
    @(posedge clk_sys);
    pcWordAddr <= pc;
    {flashPointerHigh, flashPointerLow} <= zp;
    lpmStrobe <= 1'b1;
    @(posedge clk_sys);
    lpmStrobe <= 1'b0;
    #1;
    chk(lpmValid, 1, "load valid");
    chk(lpmData, blk ? 8'hff : zp[7:0] ^ zp[15:8] ^ 8'h3c, "load data");
  endtask : lpm

  // bounded wait for the flash done pulse, then the halt must drop
  task automatic waitDone();
    int n;
    n = 0;
    while (flashDone !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n < 40, 1, "flash done");
    @(posedge clk_sys);
    #1;
    chk(cpuHalt, 0, "halt release");
  endtask : waitDone

  task automatic erasePulse();
    @(posedge clk_sys);
    chipErase <= 1'b1;
    @(posedge clk_sys);
    chipErase <= 1'b0;
    #1;
    chk(lockBits, 4'hf, "chip erase");
  endtask : erasePulse

  initial begin
    void'($urandom(84));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(resetVector, 14'h0000, "app reset vector");
    store(AppPc, bsfp_pkg::OP_ERASE, 16'h0100, 16'h0000);
    chk(storeRefused, 1, "store from app");
    $display("test reset and app store done");
    // every lock pair combination: store, load and interrupt gating
    for (int i = 0; i < 16; i++) begin
      slowMode <= i[0];
      erasePulse();
      expLock = i;
      store(BootPc, bsfp_pkg::OP_LOCK, 16'($urandom), {10'h3ff, i[3:0], 2'b00});
      chk(lockBits, expLock, "lock set");
      store(BootPc, bsfp_pkg::OP_LOCK, 16'($urandom), 16'hffff);
      chk(lockBits, expLock, "lock never raised");
      store(BootPc, bsfp_pkg::OP_ERASE, 16'h0100, 16'($urandom));
      chk(flashEraseReq, expLock[0], "app erase");
      chk(storeRefused, !expLock[0], "app erase refused");
      {flashPointerHigh, flashPointerLow} <= 16'h5555;
      if (expLock[0]) begin
        chk(cpuHalt, 0, "free region no halt");
        @(posedge clk_sys);
        #1;
        chk(flashPageAddr, 8'h02, "captured page");
        waitDone();
      end
      store(BootPc, bsfp_pkg::OP_WRITE, 16'h7800, 16'h0000);
      chk(flashWriteReq, expLock[2], "boot write");
      chk(storeRefused, !expLock[2], "boot write refused");
      if (expLock[2]) begin
        chk(cpuHalt, 1, "halt region halt");
        chk(flashPageAddr, 8'hf0, "boot page");
        waitDone();
      end
      lpm(BootPc, 16'h0123, !expLock[1]);
      lpm(AppPc, 16'h7a05, !expLock[3]);
      @(posedge clk_sys);
      vectorsInBoot <= 1'b1;
      #1;
      chk(irqSuppress, !expLock[1], "app irq");
      @(posedge clk_sys);
      pcWordAddr <= BootPc;
      vectorsInBoot <= 1'b0;
      #1;
      chk(irqSuppress, !expLock[3], "boot irq");
    end
    $display("test lock modes done");
    @(posedge clk_sys);
    extLockProgram <= 1'b1;
    extLockData <= 4'h6;
    @(posedge clk_sys);
    extLockProgram <= 1'b0;
    #1;
    chk(lockBits, expLock & 6, "external lock program");
    // erase, fill a page in random word order, write the same page
    erasePulse();
    store(BootPc, bsfp_pkg::OP_ERASE, 16'h0300, 16'h0000);
    waitDone();
    for (int w = 0; w < 64; w++) wordQ.push_back(w);
    while (wordQ.size() > 0) begin
      k = $urandom_range(wordQ.size() - 1);
      z = {9'h006, wordQ[k][5:0], 1'b0};
      wordQ.delete(k);
      store(BootPc, bsfp_pkg::OP_FILL, z, z ^ 16'ha5c3);
      chk(bufWrite, 1, "fill strobe");
      chk({bufWordAddr, bufData}, {z[6:1], z ^ 16'ha5c3}, "fill word");
    end
    store(BootPc, bsfp_pkg::OP_WRITE, 16'h0300, 16'h0000);
    chk(flashPageAddr, 8'h06, "write page");
    waitDone();
    $display("test page fill done");
    // second reset with the boot fuse programmed
    @(posedge clk_sys);
    rst_n <= 1'b0;
    bootResetSelectFuse <= 1'b0;
    nvLockBits <= 4'h9;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(resetVector, 14'h3c00, "boot reset vector");
    chk(lockBits, 4'h9, "lock reload");
    $display("test boot reset done");
    final_report();
  end
endmodule : boot_section_flash_protection_tb

/* File: bsfp_defines.svh */
// constants for the boot section flash protection block
// assumes a 16k-word flash with 64-word pages, byte pointer from the cpu
//
// Contract
// - lock bits program by software or external port; only chip erase restores ones
// - general write lock never gates store-program writes
// - general read/write lock never gates program loads or stores
// - app pair: 10 blocks writes, 00 writes and boot loads, 01 boot loads
// - app modes 3,4 with boot vectors suppress interrupts in app code
// - boot pair: 10 blocks writes, 00 writes and app loads, 01 app loads
// - boot modes 3,4 with app vectors suppress interrupts in boot code
// - reset vector is 0x0000 with fuse one, boot start with fuse zero
// - cpu can never alter any fuse
// - 16-bit pointer: low bits pick word in page, high bits the page
// - target address captured at start, later pointer changes ignored
// - lock-set operation ignores the pointer entirely
// - program load addresses bytes, pointer bit 0 picks the byte
// - buffer word loads accepted in any order within the page
// - store starts programming only when executing from boot section
// - cpu halted for whole operation on the no-read-while-write region
`ifndef BSFP_DEFINES_SVH
`define BSFP_DEFINES_SVH
`define BSFP_WADDR_W     14
`define BSFP_BOOT_START  14'h3c00
`define BSFP_HALT_START  14'h3800
`define BSFP_APP_RESET   14'h0000
`define BSFP_WORD_LSB    1
`define BSFP_WORD_MSB    6
`define BSFP_PAGE_LSB    7
`define BSFP_PAGE_MSB    14
`define BSFP_LOCK_ONES   4'hf
`define BSFP_BLOCKED_RD  8'hff
`define BSFP_LOCK_FIELD_LSB 2
`define BSFP_LOCK_FIELD_MSB 5
`define BSFP_LOAD_WAIT   2'h3
`endif

/* File: bsfp_flash_model.sv */
// flash macro stand-in: combinational byte read and an erase/write done pulse
// assumes requests arrive as one-cycle pulses on clk_sys
`timescale 1ns/100ps
module bsfp_flash_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // requests from the guard, speed select from the bench
  input  wire logic        flashEraseReq,
  input  wire logic        flashWriteReq,
  input  wire logic [15:0] flashReadAddr,
  input  wire logic        slowMode,
  // answers
  output logic             flashDone,
  output logic [7:0]       flashReadData
);
  logic [3:0] countQ;
  // hash of the byte address, so neighbouring bytes with the same high byte differ
  assign flashReadData = flashReadAddr[7:0] ^ flashReadAddr[15:8] ^ 8'h3c;
  // done after 2 or 9 cycles; slow answers stretch the halt window
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      countQ <= 4'h0;
      flashDone <= 1'b0;
    end else begin
      flashDone <= (countQ == 4'h1);
      if (flashEraseReq || flashWriteReq) countQ <= slowMode ? 4'h9 : 4'h2;
      else if (countQ != 4'h0) countQ <= countQ - 4'h1;
    end
  end
endmodule : bsfp_flash_model

/* File: bsfp_guard.sv */
// boot section flash protection: lock decode, store/load gating, reset vector
// assumes cpu strobes on clk_sys; flash macro answers with a done pulse
`include "bsfp_defines.svh"
`timescale 1ns/100ps
module bsfp_guard (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  // cpu execution context
  input  wire logic [`BSFP_WADDR_W-1:0] pcWordAddr,
  input  wire logic                     vectorsInBoot,
  // store-program instruction
  input  wire logic                     storeStrobe,
  input  wire bsfp_pkg::bsfp_op_t       storeOp,
  input  wire logic [7:0]               flashPointerHigh,
  input  wire logic [7:0]               flashPointerLow,
  input  wire logic [15:0]              storeData,
  // program load instruction
  input  wire logic                     lpmStrobe,
  input  wire logic [7:0]               flashReadData,
  // external programming interface and pins
  input  wire logic                     bootResetSelectFuse,
  input  wire logic [3:0]               nvLockBits,
  input  wire logic                     extLockProgram,
  input  wire logic [3:0]               extLockData,
  input  wire logic                     chipErase,
  // flash macro
  input  wire logic                     flashDone,
  output logic                          flashEraseReq,
  output logic                          flashWriteReq,
  output logic [7:0]                    flashPageAddr,
  output logic                          bufWrite,
  output logic [5:0]                    bufWordAddr,
  output logic [15:0]                   bufData,
  output logic [15:0]                   flashReadAddr,
  // answers to the cpu
  output logic [7:0]                    lpmData,
  output logic                          lpmValid,
  output logic                          storeRefused,
  output logic                          cpuHalt,
  output logic                          irqSuppress,
  output logic [`BSFP_WADDR_W-1:0]      resetVector,
  output logic [3:0]                    lockBits
);

  // pin synchronisers, first stage read only by second
  logic       fuseMetaQ, fuseSyncQ;
  logic [3:0] nvMetaQ, nvSyncQ;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fuseMetaQ <= 1'b1;
      fuseSyncQ <= 1'b1;
      nvMetaQ   <= `BSFP_LOCK_ONES;
      nvSyncQ   <= `BSFP_LOCK_ONES;
    end else begin
      fuseMetaQ <= bootResetSelectFuse;
      fuseSyncQ <= fuseMetaQ;
      nvMetaQ   <= nvLockBits;
      nvSyncQ   <= nvMetaQ;
    end
  end

  // lock bits: nonvolatile copy taken once the synchroniser has settled
  // three copy edges: the second stage only holds the pin value at the third
  logic [1:0] loadCntQ;
  logic       lockReady;
  logic [3:0] lockQ, lockD;
  assign lockReady = (loadCntQ == `BSFP_LOAD_WAIT);

  // pointer and target decode
  logic [15:0]              zPtr;
  logic [`BSFP_WADDR_W-1:0] zWord;
  logic                     execBoot, tgtBoot, tgtHalt;
  assign zPtr     = {flashPointerHigh, flashPointerLow};
  assign zWord    = zPtr[`BSFP_PAGE_MSB:`BSFP_WORD_LSB];
  assign execBoot = (pcWordAddr >= `BSFP_BOOT_START);
  assign tgtBoot  = (zWord >= `BSFP_BOOT_START);
  assign tgtHalt  = (zWord >= `BSFP_HALT_START);

  // lock pair decode; general lock bits never enter these terms
  logic appWrBlk, appRdBlk, bootWrBlk, bootRdBlk;
  assign appWrBlk  = ~lockQ[0]; // low bit programmed blocks writes
  assign appRdBlk  = ~lockQ[1]; // high bit programmed blocks loads
  assign bootWrBlk = ~lockQ[2];
  assign bootRdBlk = ~lockQ[3];

  // store gating: only boot code may program
  logic storeOk, pageOp, wrBlocked, startOp, lockSet, fillOk;
  bsfp_pkg::bsfp_state_t stateQ, stateD;
  assign storeOk   = storeStrobe & execBoot & lockReady;
  assign pageOp    = (storeOp == bsfp_pkg::OP_ERASE) | (storeOp == bsfp_pkg::OP_WRITE);
  assign wrBlocked = tgtBoot ? bootWrBlk : appWrBlk;
  assign startOp   = storeOk & pageOp & ~wrBlocked & (stateQ == bsfp_pkg::ST_IDLE);
  assign lockSet   = storeOk & (storeOp == bsfp_pkg::OP_LOCK); // no pointer term
  assign fillOk    = storeOk & (storeOp == bsfp_pkg::OP_FILL) & (stateQ == bsfp_pkg::ST_IDLE);

  // lock update: program only clears bits, chip erase alone sets them
  always_comb begin
    lockD = lockQ;
    if (!lockReady)
      lockD = nvSyncQ;
    else if (chipErase)
      lockD = `BSFP_LOCK_ONES;
    else begin
      if (lockSet)
        lockD = lockD & storeData[`BSFP_LOCK_FIELD_MSB:`BSFP_LOCK_FIELD_LSB];
      if (extLockProgram)
        lockD = lockD & extLockData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loadCntQ <= 2'h0;
      lockQ    <= `BSFP_LOCK_ONES;
    end else begin
      loadCntQ <= lockReady ? loadCntQ : loadCntQ + 2'h1;
      lockQ    <= lockD;
    end
  end
  assign lockBits = lockQ;

  // sequencer: halt only for the region the cpu cannot read
  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      bsfp_pkg::ST_IDLE:
        if (startOp)
          stateD = tgtHalt ? bsfp_pkg::ST_HALT : bsfp_pkg::ST_BUSY;
      bsfp_pkg::ST_BUSY,
      bsfp_pkg::ST_HALT:
        if (flashDone)
          stateD = bsfp_pkg::ST_IDLE;
      default:
        stateD = bsfp_pkg::ST_IDLE;
    endcase
  end

  // page captured at start so the pointer is free afterwards
  logic [7:0] pageQ;
  logic       eraseQ, writeQ;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= bsfp_pkg::ST_IDLE;
      pageQ  <= 8'h00;
      eraseQ <= 1'b0;
      writeQ <= 1'b0;
    end else begin
      stateQ <= stateD;
      if (startOp)
        pageQ <= zPtr[`BSFP_PAGE_MSB:`BSFP_PAGE_LSB];
      eraseQ <= startOp & (storeOp == bsfp_pkg::OP_ERASE);
      writeQ <= startOp & (storeOp == bsfp_pkg::OP_WRITE);
    end
  end
  assign flashEraseReq = eraseQ;
  assign flashWriteReq = writeQ;
  assign flashPageAddr = pageQ;
  assign cpuHalt       = (stateQ == bsfp_pkg::ST_HALT);

  // buffer fill: word index taken straight from pointer, any order
  logic        bufWrQ, refuseQ;
  logic [5:0]  bufAddrQ;
  logic [15:0] bufDataQ;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bufWrQ   <= 1'b0;
      bufAddrQ <= 6'h00;
      bufDataQ <= 16'h0000;
      refuseQ  <= 1'b0;
    end else begin
      bufWrQ <= fillOk;
      if (fillOk) begin
        bufAddrQ <= zPtr[`BSFP_WORD_MSB:`BSFP_WORD_LSB];
        bufDataQ <= storeData;
      end
      refuseQ <= storeStrobe & ~(startOp | lockSet | fillOk);
    end
  end
  assign bufWrite     = bufWrQ;
  assign bufWordAddr  = bufAddrQ;
  assign bufData      = bufDataQ;
  assign storeRefused = refuseQ;

  // load gating: cross-section reads only, byte address
  logic rdBlocked;
  assign flashReadAddr = zPtr; // bit 0 picks the byte
  assign rdBlocked = tgtBoot ? (~execBoot & bootRdBlk)
                             : (execBoot & appRdBlk);
  logic [7:0] lpmDataQ;
  logic       lpmValidQ;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lpmDataQ  <= 8'h00;
      lpmValidQ <= 1'b0;
    end else begin
      lpmValidQ <= lpmStrobe;
      if (lpmStrobe)
        lpmDataQ <= rdBlocked ? `BSFP_BLOCKED_RD : flashReadData;
    end
  end
  assign lpmData  = lpmDataQ;
  assign lpmValid = lpmValidQ;

  // interrupt suppression while running in the locked-away section
  logic irqOff;
  assign irqOff = (vectorsInBoot & ~execBoot & appRdBlk)
                | (~vectorsInBoot & execBoot & bootRdBlk);
  assign irqSuppress = irqOff;

  // reset vector from the fuse; fuse has no cpu write path at all
  logic [`BSFP_WADDR_W-1:0] rstVecQ;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      rstVecQ <= `BSFP_APP_RESET;
    else
      rstVecQ <= fuseSyncQ ? `BSFP_APP_RESET : `BSFP_BOOT_START;
  end
  assign resetVector = rstVecQ;

  // checks
  sequence s_start_halt_region;
    startOp && tgtHalt;
  endsequence
  sequence s_halted_to_done;
    cpuHalt ##0 flashDone;
  endsequence

  a_blocked_no_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (storeOk && pageOp && wrBlocked) |=> !flashEraseReq && !flashWriteReq)
    else $error("write to locked section started");
  a_app_no_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (storeStrobe && !execBoot) |=> !flashEraseReq && !flashWriteReq && !bufWrite)
    else $error("store from application section took effect");
  a_halt_region_halts: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_start_halt_region |=> cpuHalt)
    else $error("no halt for no-read-while-write target");
  a_free_region_runs: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (startOp && !tgtHalt) |=> !cpuHalt && (stateQ == bsfp_pkg::ST_BUSY))
    else $error("halted for read-while-write target");
  a_halt_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_halted_to_done |=> !cpuHalt)
    else $error("halt held after flash done");
  a_page_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stateQ != bsfp_pkg::ST_IDLE) |=> $stable(flashPageAddr) || $past(startOp))
    else $error("page address moved during operation");
  a_lock_no_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lockReady && !$past(chipErase) && $past(lockReady)) |-> ((lockQ & ~$past(lockQ)) == 4'h0))
    else $error("lock bit returned to one without chip erase");
  a_load_hidden: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lpmStrobe && !tgtBoot && execBoot && !lockQ[1]) |=> lpmData == `BSFP_BLOCKED_RD)
    else $error("protected application byte returned");
  a_boot_irq_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!vectorsInBoot && execBoot && !lockQ[3]) |-> irqSuppress)
    else $error("interrupt not suppressed in boot code");
  a_app_irq_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (vectorsInBoot && !execBoot && !lockQ[1]) |-> irqSuppress)
    else $error("interrupt not suppressed in application code");
  a_reset_vector: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fuseSyncQ |=> resetVector == `BSFP_APP_RESET)
    else $error("reset vector not application start");
  a_boot_vector: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !fuseSyncQ |=> resetVector == `BSFP_BOOT_START)
    else $error("reset vector not boot start");
  a_fill_index: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fillOk |=> bufWrite && bufWordAddr == $past(zPtr[6:1]))
    else $error("buffer word index wrong");

  // lock state and store answers
  a_lock_set_and: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lockSet && !chipErase && !extLockProgram) |=> lockBits == ($past(lockBits)
      & $past(storeData[`BSFP_LOCK_FIELD_MSB:`BSFP_LOCK_FIELD_LSB])))
    else $error("lock set did not clear the requested bits");
  a_erase_all_ones: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (chipErase && lockReady) |=> lockBits == `BSFP_LOCK_ONES)
    else $error("chip erase left a lock bit programmed");
  a_lock_any_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (storeOk && storeOp == bsfp_pkg::OP_LOCK) |=> !storeRefused)
    else $error("lock set from boot code refused");
  a_app_store_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (storeStrobe && !execBoot) |=> storeRefused)
    else $error("store from application section not refused");
  a_app_wr_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (storeOk && pageOp && !tgtBoot && !lockQ[0]) |=> storeRefused)
    else $error("application page op not refused");
  a_boot_wr_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (storeOk && pageOp && tgtBoot && !lockQ[2]) |=> storeRefused)
    else $error("boot page op not refused");
  a_one_request: assert property (@(posedge clk_sys) disable iff (!rst_n)
    startOp |=> flashEraseReq != flashWriteReq)
    else $error("started operation gave no single request");
  a_fill_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fillOk |=> bufData == $past(storeData))
    else $error("buffer word data wrong");
  // loads and interrupts
  a_load_valid: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lpmStrobe |=> lpmValid)
    else $error("load not answered");
  a_boot_load_hidden: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lpmStrobe && tgtBoot && !execBoot && !lockQ[3]) |=> lpmData == `BSFP_BLOCKED_RD)
    else $error("protected boot byte returned");
  a_open_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lpmStrobe && lockQ[1] && lockQ[3]) |=> lpmData == $past(flashReadData))
    else $error("unlocked load did not return the flash byte");
  a_irq_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lockQ[1] && lockQ[3]) |-> !irqSuppress)
    else $error("interrupt suppressed without read lock");

endmodule : bsfp_guard

/* File: bsfp_pkg.sv */
// types for the boot section flash protection block
// assumes bsfp_defines.svh is compiled alongside
package bsfp_pkg;
  // store-program operation chosen by the cpu
  typedef enum logic [1:0] {
    OP_FILL  = 2'h0,
    OP_ERASE = 2'h1,
    OP_WRITE = 2'h2,
    OP_LOCK  = 2'h3
  } bsfp_op_t;
  // programming sequencer, gray along idle-busy-halt
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BUSY = 2'h1,
    ST_HALT = 2'h3
  } bsfp_state_t;
endpackage : bsfp_pkg
